//--- rtl/fbr_top.sv
// Control side of a low-side switch: frame bus, source select, readback, supply status
`timescale 1ns/100ps

module fbr_top #(
   parameter int STAGES = fbr_pkg::NUM_STAGES
) (
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   // Pins from outside the clock domain
   input  wire logic [STAGES:1]   par_pin_in,
   input  wire logic              frame_data_pin_in,
   input  wire logic              frame_clock_pin_in,
   input  wire logic              frame_sync_pin_in,
   input  wire logic              ext_rst_n_in,
   input  wire logic              output_enable_line_in,
   output logic                   output_enable_line_out,
   output logic                   output_enable_line_oe_n_out,
   // Analog monitor levels
   input  wire logic              supply_uv_in,
   input  wire logic              supply_ov_in,
   input  wire logic              supply_above_3v5_in,
   // Same-domain diagnostic and serial control logic
   input  wire logic [4:0]        stage_fault_any_in,
   input  wire logic              overtemp_event_in,
   input  wire logic [STAGES:1]   stage_source_mux_serial_in,
   input  wire logic [STAGES:1]   serial_stage_on_in,
   // Register command port
   input  wire logic              cmd_valid_in,
   input  wire logic [3:0]        cmd_code_in,
   input  wire logic [7:0]        cmd_wdata_in,
   output logic                   rd_valid_out,
   output logic      [7:0]        rd_data_out,
   // Towards the analog side
   output logic      [STAGES:1]   stage_on_out,
   output logic      [STAGES:1]   pull_up_en_out,
   output logic                   threshold_raise_lower_out,
   output logic                   threshold_reduce_upper_out
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (STAGES != fbr_pkg::NUM_STAGES) begin : g_bad_stages
      $error("stage count must be 16");
   end

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   localparam int AW = 8;
   logic [STAGES:1] pin_s;
   logic [AW-1:0]   misc_s;
   logic            fclk_s, fdata_s, fsync_s, ext_rst_n_s;
   logic            en_line_s, uv_s, ov_s, above_s;

   // All pins pass two flops before any logic looks at them
   fbr_sync #(.W(STAGES)) u_pin_sync (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .async_in (par_pin_in),
      .sync_out (pin_s)
   );

   fbr_sync #(.W(AW)) u_misc_sync (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .async_in ({frame_clock_pin_in, frame_data_pin_in, frame_sync_pin_in, ext_rst_n_in,
                  output_enable_line_in, supply_uv_in, supply_ov_in, supply_above_3v5_in}),
      .sync_out (misc_s)
   );

   assign {fclk_s, fdata_s, fsync_s, ext_rst_n_s, en_line_s, uv_s, ov_s, above_s} = misc_s;

   // ----------------------------------------------------------------
   // Frame receiver
   // ----------------------------------------------------------------
   logic [fbr_pkg::FRAME_BITS-1:0] frame_word;

   fbr_frame_rx #(.BITS(fbr_pkg::FRAME_BITS)) u_frame_rx (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .fclk_s_in  (fclk_s),
      .fdata_s_in (fdata_s),
      .fsync_s_in (fsync_s),
      .frame_out  (frame_word)
   );

   // ----------------------------------------------------------------
   // Configuration and status state
   // ----------------------------------------------------------------
   logic [7:0] cfg_reg, cfg_next;
   logic [2:0] stat_cfg_reg, stat_cfg_next;
   logic       ov_store_reg, ov_store_next;
   logic       ot_ok_reg, ot_ok_next;
   logic       wr_cfg, wr_stat, clr_diag, ext_rst;

   // Positions of the writable bits within the three-bit status copy
   localparam int SC_LATCH = fbr_pkg::ST_OV_LATCH - fbr_pkg::ST_OV_LATCH;
   localparam int SC_SEL   = fbr_pkg::ST_TEST_SEL - fbr_pkg::ST_OV_LATCH;
   localparam int SC_OFF   = fbr_pkg::ST_TEST_OFF - fbr_pkg::ST_OV_LATCH;

   assign wr_cfg   = cmd_valid_in && (cmd_code_in == fbr_pkg::CMD_WR_CFG);
   assign wr_stat  = cmd_valid_in && (cmd_code_in == fbr_pkg::CMD_WR_STAT);
   assign clr_diag = cmd_valid_in && (cmd_code_in == fbr_pkg::CMD_CLR_DIAG);
   assign ext_rst  = !ext_rst_n_s;

   // Writes and the two sticky supply/temperature flags; a set in the
   // same cycle as a clear wins so no event is lost
   always_comb begin
      cfg_next      = cfg_reg;
      stat_cfg_next = stat_cfg_reg;
      ov_store_next = ov_store_reg;
      ot_ok_next    = ot_ok_reg;
      if (wr_cfg) begin
         cfg_next = cmd_wdata_in;
         cfg_next[fbr_pkg::CFG_FIXED_ONE] = 1'b1;
      end
      if (wr_stat) begin
         stat_cfg_next = cmd_wdata_in[fbr_pkg::ST_TEST_OFF:fbr_pkg::ST_OV_LATCH];
      end
      // Only undervoltage or latch disable erase it, not the reset pin
      if (uv_s || !stat_cfg_next[SC_LATCH]) begin
         ov_store_next = 1'b0;
      end
      if (ov_s && stat_cfg_next[SC_LATCH]) begin
         ov_store_next = 1'b1;
      end
      if (clr_diag || ext_rst || uv_s) begin
         ot_ok_next = 1'b1;
      end
      if (overtemp_event_in) begin
         ot_ok_next = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cfg_reg      <= fbr_pkg::CFG_RST;
         stat_cfg_reg <= fbr_pkg::STAT_CFG_RST;
         ov_store_reg <= 1'b0;
         ot_ok_reg    <= 1'b1;
      end else begin
         cfg_reg      <= cfg_next;
         stat_cfg_reg <= stat_cfg_next;
         ov_store_reg <= ov_store_next;
         ot_ok_reg    <= ot_ok_next;
      end
   end

   // ----------------------------------------------------------------
   // Read answers
   // ----------------------------------------------------------------
   logic       bus_sel;
   logic [7:0] inp_lo, inp_hi, stat_word;
   logic [7:0] rdata_reg, rdata_next;
   logic       rvalid_reg, rvalid_next;

   assign bus_sel = cfg_reg[fbr_pkg::CFG_BUS_SEL];

   // Live pin images; input 8 reported inverted
   always_comb begin
      inp_lo      = {1'b0, frame_word[fbr_pkg::TEST_BIT_D], 1'b0, pin_s[5:1]};
      inp_lo[fbr_pkg::INLO_IN8] = !pin_s[fbr_pkg::STAGE_EIGHT];
      inp_hi      = {1'b0, pin_s[15:9]};
      stat_word   = {stat_cfg_reg,
                     ot_ok_reg,
                     !(|stage_fault_any_in),
                     en_line_s,
                     !uv_s,
                     !(ov_s || ov_store_reg)};
   end

   // One registered answer per read command, one cycle after it
   always_comb begin
      rvalid_next = 1'b0;
      rdata_next  = rdata_reg;
      if (cmd_valid_in) begin
         case (cmd_code_in)
            fbr_pkg::CMD_RD_INP_LO: begin
               rvalid_next = 1'b1;
               rdata_next  = inp_lo;
            end
            fbr_pkg::CMD_RD_INP_HI: begin
               rvalid_next = 1'b1;
               rdata_next  = inp_hi;
            end
            fbr_pkg::CMD_RD_STAT: begin
               rvalid_next = 1'b1;
               rdata_next  = stat_word;
            end
            fbr_pkg::CMD_RD_CFG: begin
               rvalid_next = 1'b1;
               rdata_next  = cfg_reg;
            end
            default: begin
               rvalid_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign rd_valid_out = rvalid_reg;
   assign rd_data_out  = rdata_reg;

   // ----------------------------------------------------------------
   // Stage source selection
   // ----------------------------------------------------------------
   logic [STAGES:1] frame_on, stage_next, stage_reg;
   logic [STAGES:1] pull_next, pull_reg;
   logic            en_drive_low, en_oe_n_next, en_oe_n_reg;
   logic [1:0]      test_next, test_reg;

   // Unscramble the frame word; a zero bit means the stage is on
   always_comb begin
      frame_on = '0;
      for (int d = 0; d < fbr_pkg::FRAME_BITS; d++) begin
         if (fbr_pkg::fbr_frame_stage(d) != 0) begin
            frame_on[fbr_pkg::fbr_frame_stage(d)] = !frame_word[d];
         end
      end
   end

   // Enable line pulled low while the supply is out of range or an
   // overvoltage is still stored
   assign en_drive_low = uv_s || ov_s || ov_store_reg;

   // Per-stage source, then shutdown by reset pin and enable line.
   // Stage 8 on its input pin only falls to overvoltage or a supply
   // below 3.5V, so that a limp-home load survives a reset pulse.
   always_comb begin
      stage_next = '0;
      for (int k = 1; k <= STAGES; k++) begin
         if (k == fbr_pkg::STAGE_EIGHT) begin
            if (stage_source_mux_serial_in[k]) begin
               stage_next[k] = serial_stage_on_in[k] && !ext_rst && en_line_s;
            end else begin
               stage_next[k] = !pin_s[k] && above_s && !ov_s;
            end
         end else begin
            if (stage_source_mux_serial_in[k]) begin
               stage_next[k] = bus_sel ? serial_stage_on_in[k] : frame_on[k];
            end else begin
               stage_next[k] = pin_s[k];
            end
            stage_next[k] = stage_next[k] && !ext_rst && en_line_s;
         end
      end
      pull_next = '0;
      for (int k = 1; k <= STAGES; k++) begin
         pull_next[k] = ((k <= 5) || ((k >= 9) && (k <= 15))) ? bus_sel : 1'b1;
      end
      en_oe_n_next  = !en_drive_low;
      test_next     = {!stat_cfg_reg[SC_OFF] && stat_cfg_reg[SC_SEL],
                       !stat_cfg_reg[SC_OFF] && !stat_cfg_reg[SC_SEL]};
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         stage_reg   <= '0;
         pull_reg    <= '1;
         en_oe_n_reg <= 1'b0;
         test_reg    <= 2'h0;
      end else begin
         stage_reg   <= stage_next;
         pull_reg    <= pull_next;
         en_oe_n_reg <= en_oe_n_next;
         test_reg    <= test_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain: only ever drives low, enable is active low
   assign output_enable_line_out      = 1'b0;
   assign output_enable_line_oe_n_out = en_oe_n_reg;
   assign stage_on_out                = stage_reg;
   assign pull_up_en_out              = pull_reg;
   assign threshold_raise_lower_out   = test_reg[1];
   assign threshold_reduce_upper_out  = test_reg[0];
endmodule : fbr_top

//--- rtl/fbr_pkg.sv
// Shared constants for the frame bus receiver and input/status block
package fbr_pkg;
   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int          FRAME_BITS      = 16;
   localparam int          NUM_STAGES      = 16;
   localparam int          REG_W           = 8;
   localparam int          SYNC_STAGES     = 2;
   localparam int          TEST_BIT_D      = 8;
   // ----------------------------------------------------------------
   // Command codes on the register command port
   // ----------------------------------------------------------------
   localparam logic [3:0]  CMD_RD_INP_LO   = 4'h1;
   localparam logic [3:0]  CMD_RD_INP_HI   = 4'h2;
   localparam logic [3:0]  CMD_RD_STAT     = 4'h3;
   localparam logic [3:0]  CMD_WR_STAT     = 4'h4;
   localparam logic [3:0]  CMD_RD_CFG      = 4'h5;
   localparam logic [3:0]  CMD_WR_CFG      = 4'h6;
   localparam logic [3:0]  CMD_CLR_DIAG    = 4'h7;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] FRAME_RST       = 16'hffff;
   localparam logic [7:0]  CFG_RST         = 8'hff;
   localparam logic [2:0]  STAT_CFG_RST    = 3'h7;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          CFG_BUS_SEL     = 1;
   localparam int          CFG_FIXED_ONE   = 0;
   localparam int          ST_OV           = 0;
   localparam int          ST_UV           = 1;
   localparam int          ST_EN_LINE      = 2;
   localparam int          ST_ERR          = 3;
   localparam int          ST_OT           = 4;
   localparam int          ST_OV_LATCH     = 5;
   localparam int          ST_TEST_SEL     = 6;
   localparam int          ST_TEST_OFF     = 7;
   localparam int          INLO_TEST       = 6;
   localparam int          INLO_IN8        = 7;
   localparam int          STAGE_EIGHT     = 8;

   // Stage number (1..16) driven by each frame bit; 0 means none
   function automatic int fbr_frame_stage(input int d);
      case (d)
         0:       fbr_frame_stage = 14;
         9:       fbr_frame_stage = 11;
         10:      fbr_frame_stage = 10;
         11:      fbr_frame_stage = 9;
         12:      fbr_frame_stage = 12;
         13:      fbr_frame_stage = 13;
         14:      fbr_frame_stage = 16;
         15:      fbr_frame_stage = 15;
         8:       fbr_frame_stage = 0;
         default: fbr_frame_stage = d;
      endcase
   endfunction : fbr_frame_stage
endpackage : fbr_pkg

//--- rtl/fbr_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module fbr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   // Refuse a width the flops cannot hold
   if (W < 1) begin : g_bad_width
      $error("synchroniser width must be at least one");
   end

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] hold_reg;
   logic [W-1:0] hold_next;

   // First stage feeds only the second stage
   always_comb begin
      meta_next = async_in;
      hold_next = meta_reg;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         meta_reg <= '0;
         hold_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         hold_reg <= hold_next;
      end
   end

   assign sync_out = hold_reg;
endmodule : fbr_sync

//--- rtl/fbr_frame_rx.sv
// Frame bus receiver: shifts data on frame clock rises, loads on sync rise
`timescale 1ns/100ps
module fbr_frame_rx #(
   parameter int BITS = fbr_pkg::FRAME_BITS
) (
   input  wire logic            clk_in,
   input  wire logic            srst_in,
   input  wire logic            fclk_s_in,
   input  wire logic            fdata_s_in,
   input  wire logic            fsync_s_in,
   output logic      [BITS-1:0] frame_out
);
   localparam int CW = $clog2(BITS);

   // Bit counter and stage map are sized for one frame length only
   if (BITS != fbr_pkg::FRAME_BITS) begin : g_bad_bits
      $error("frame width must be 16");
   end

   logic            fclk_d_reg, fclk_d_next;
   logic            fsync_d_reg, fsync_d_next;
   logic [CW-1:0]   cnt_reg, cnt_next;
   logic [BITS-1:0] shift_reg, shift_next;
   logic [BITS-1:0] hold_reg, hold_next;

   // Edge finding on the synchronised pins; a short frame just leaves
   // the old bits in the upper positions, no error is flagged
   always_comb begin
      fclk_d_next  = fclk_s_in;
      fsync_d_next = fsync_s_in;
      cnt_next     = cnt_reg;
      shift_next   = shift_reg;
      hold_next    = hold_reg;
      if (fclk_s_in && !fclk_d_reg) begin
         shift_next[cnt_reg] = fdata_s_in;
         cnt_next            = cnt_reg + 1'b1;
      end
      if (fsync_s_in && !fsync_d_reg) begin
         hold_next = shift_reg;
         cnt_next  = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         fclk_d_reg  <= 1'b0;
         fsync_d_reg <= 1'b0;
         cnt_reg     <= '0;
         shift_reg   <= fbr_pkg::FRAME_RST;
         hold_reg    <= fbr_pkg::FRAME_RST;
      end else begin
         fclk_d_reg  <= fclk_d_next;
         fsync_d_reg <= fsync_d_next;
         cnt_reg     <= cnt_next;
         shift_reg   <= shift_next;
         hold_reg    <= hold_next;
      end
   end

   assign frame_out = hold_reg;
endmodule : fbr_frame_rx

//--- sim/fbr_monitor.sv
// Port-level assertions for the frame bus receiver top
`timescale 1ns/100ps
module fbr_monitor #(
   parameter int STAGES = 16
) (
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  wire logic              ext_rst_n_in,
   input  wire logic              supply_ov_in,
   input  wire logic              cmd_valid_in,
   input  wire logic [3:0]        cmd_code_in,
   input  wire logic [7:0]        cmd_wdata_in,
   input  wire logic              rd_valid_out,
   input  wire logic [7:0]        rd_data_out,
   input  wire logic [STAGES:1]   stage_on_out,
   input  wire logic [STAGES:1]   pull_up_en_out,
   input  wire logic              threshold_raise_lower_out,
   input  wire logic              threshold_reduce_upper_out
);
   // ----------------------------------------------------------------
   // Command decode helpers
   // ----------------------------------------------------------------
   logic is_rd;
   logic wr_cfg;
   logic wr_stat;
   logic rd_stat;
   // Only reads get an answer, unknown codes stay silent
   assign is_rd   = cmd_valid_in && (cmd_code_in == fbr_pkg::CMD_RD_INP_LO || cmd_code_in == fbr_pkg::CMD_RD_INP_HI
                    || cmd_code_in == fbr_pkg::CMD_RD_STAT || cmd_code_in == fbr_pkg::CMD_RD_CFG);
   assign wr_cfg  = cmd_valid_in && cmd_code_in == fbr_pkg::CMD_WR_CFG;
   assign wr_stat = cmd_valid_in && cmd_code_in == fbr_pkg::CMD_WR_STAT;
   assign rd_stat = cmd_valid_in && cmd_code_in == fbr_pkg::CMD_RD_STAT;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Five samples cover the synchroniser plus the output register
   sequence ext_rst_held;
      !ext_rst_n_in [*5];
   endsequence
   sequence ov_held;
      supply_ov_in [*5];
   endsequence

   rd_answer_a: assert property (is_rd |=> rd_valid_out)
      else $error("read command got no answer");
   rd_pulse_a: assert property (rd_valid_out |-> $past(is_rd))
      else $error("read answer without read command");
   rd_hold_a: assert property (!rd_valid_out |-> $stable(rd_data_out))
      else $error("read data changed between reads");
   hi_bit_zero_a: assert property (is_rd && cmd_code_in == fbr_pkg::CMD_RD_INP_HI |=> !rd_data_out[7])
      else $error("unused readback bit not zero");
   pullup_fixed_a: assert property (pull_up_en_out[8:6] == 3'h7 && pull_up_en_out[16])
      else $error("pull-up of unaffected input changed");
   pullup_follow_a: assert property (wr_cfg |-> ##2 (
      pull_up_en_out[5:1] == {5{$past(cmd_wdata_in[1], 2)}}
      && pull_up_en_out[15:9] == {7{$past(cmd_wdata_in[1], 2)}})) else $error("pull-ups do not follow bus select");
   test_excl_a: assert property (!(threshold_raise_lower_out && threshold_reduce_upper_out))
      else $error("both threshold tests active");
   test_follow_a: assert property (wr_stat |-> ##2 (threshold_raise_lower_out ==
      (!$past(cmd_wdata_in[7], 2) && $past(cmd_wdata_in[6], 2)) && threshold_reduce_upper_out ==
      (!$past(cmd_wdata_in[7], 2) && !$past(cmd_wdata_in[6], 2)))) else $error("threshold test outputs wrong");
   ext_rst_off_a: assert property (ext_rst_held |->
      stage_on_out[7:1] == 7'h00 && stage_on_out[16:9] == 8'h00)
      else $error("stage on during reset pin low");
   ov_read_a: assert property (ov_held ##0 rd_stat |=> !rd_data_out[0])
      else $error("overvoltage not reported");
endmodule : fbr_monitor

bind fbr_top fbr_monitor #(.STAGES(STAGES)) mon_u (.clk_in(clk_in), .srst_in(srst_in), .ext_rst_n_in(ext_rst_n_in),
   .supply_ov_in(supply_ov_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
   .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .stage_on_out(stage_on_out),
   .pull_up_en_out(pull_up_en_out), .threshold_raise_lower_out(threshold_raise_lower_out),
   .threshold_reduce_upper_out(threshold_reduce_upper_out));

//--- sim/fbr_frame_host.sv
// Behavioural host driving the frame data, clock and sync pins
`timescale 1ns/100ps
module fbr_frame_host (
   output logic frame_data_out,
   output logic frame_clock_out,
   output logic frame_sync_out
);
   // Clock parked low, no frame in flight
   initial begin
      frame_data_out  = 1'b0;
      frame_clock_out = 1'b0;
      frame_sync_out  = 1'b0;
   end
   // Shifts n bits D0 first, 160 ns clock, data moved only while clock low
   task automatic send(input logic [15:0] word, input int n);
      for (int i = 0; i < n; i++) begin
         frame_data_out = word[i];
         #40 frame_clock_out = 1'b1;
         #80 frame_clock_out = 1'b0;
         #40;
      end
      // Released line shows the inverse so a held value cannot pass
      frame_data_out = ~frame_data_out;
      #40 frame_sync_out = 1'b1;
      #160 frame_sync_out = 1'b0;
      #40;
   endtask : send
endmodule : fbr_frame_host

//--- sim/testbench.sv
// Self-checking bench for the frame bus receiver top
`timescale 1ns/100ps
module testbench;
   logic        clk_in;
   logic        srst_in;
   logic [16:1] par_pin;
   logic        ext_rst_n;
   logic        en_ext;
   logic        en_line;
   logic        en_drv;
   logic        en_oe_n;
   logic        uv;
   logic        ov;
   logic        above;
   logic [4:0]  fault;
   logic        ot;
   logic [16:1] mux_serial;
   logic [16:1] serial_on;
   logic        cmd_valid;
   logic [3:0]  cmd_code;
   logic [7:0]  cmd_wdata;
   logic        rd_valid;
   logic [7:0]  rd_data;
   logic [16:1] stage_on;
   logic [16:1] pull_up;
   logic        raise;
   logic        reduce;
   logic        fdata;
   logic        fclk;
   logic        fsync;
   int          n_mismatch;
   int          samples_checked;
   int          cycles;

   // Open-drain enable line: bench pull-up, device pulls low when enabled
   assign en_line = en_ext & (en_oe_n | en_drv);

   fbr_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .par_pin_in(par_pin), .frame_data_pin_in(fdata),
      .frame_clock_pin_in(fclk), .frame_sync_pin_in(fsync), .ext_rst_n_in(ext_rst_n),
      .output_enable_line_in(en_line), .output_enable_line_out(en_drv), .output_enable_line_oe_n_out(en_oe_n),
      .supply_uv_in(uv), .supply_ov_in(ov), .supply_above_3v5_in(above), .stage_fault_any_in(fault),
      .overtemp_event_in(ot), .stage_source_mux_serial_in(mux_serial), .serial_stage_on_in(serial_on),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .rd_valid_out(rd_valid),
      .rd_data_out(rd_data), .stage_on_out(stage_on), .pull_up_en_out(pull_up),
      .threshold_raise_lower_out(raise), .threshold_reduce_upper_out(reduce));
   fbr_frame_host host_u (.frame_data_out(fdata), .frame_clock_out(fclk), .frame_sync_out(fsync));

   // ----------------------------------------------------------------
   // Clock, hang guard and tasks
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // Whole run needs about 400 cycles; ceiling leaves ample margin
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic summarize;
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One-cycle strobe, released one edge later so calls never collide
   task automatic cmd(input logic [3:0] code, input logic [7:0] wdata);
      @(posedge clk_in);
      #1 cmd_valid = 1'b1;
      cmd_code = code;
      cmd_wdata = wdata;
      @(posedge clk_in);
      #1 cmd_valid = 1'b0;
   endtask : cmd
   task automatic rd(input logic [3:0] code, input logic [7:0] exp);
      cmd(code, 8'h00);
      check("read strobe", {15'h0000, rd_valid}, 16'h0001);
      check("read data", {8'h00, rd_data}, {8'h00, exp});
   endtask : rd
   // Covers pin synchronisers plus output register
   task automatic settle;
      repeat (8) @(posedge clk_in);
      #1;
   endtask : settle
   task automatic hot;
      ot = 1'b1;
      @(posedge clk_in);
      #1 ot = 1'b0;
   endtask : hot

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      srst_in = 1'b1;
      par_pin = 16'hd316;
      ext_rst_n = 1'b1;
      en_ext = 1'b1;
      uv = 1'b0;
      ov = 1'b0;
      above = 1'b1;
      fault = 5'h00;
      ot = 1'b0;
      mux_serial = 16'hffff;
      serial_on = 16'h0000;
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_wdata = 8'h00;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(posedge clk_in);
      #1 srst_in = 1'b0;
      settle();
      rd(fbr_pkg::CMD_RD_STAT, 8'hff);
      rd(fbr_pkg::CMD_RD_CFG, 8'hff);
      check("pull ups", pull_up, 16'hffff);
      rd(fbr_pkg::CMD_RD_INP_HI, 8'h53);
      rd(fbr_pkg::CMD_RD_INP_LO, 8'hd6);
      // Unknown code: no answer, last read data stands
      cmd(4'hf, 8'h00);
      check("no answer", {7'h00, rd_valid, rd_data}, 16'h00d6);
      // Frame bus as source, full then short frame
      cmd(fbr_pkg::CMD_WR_CFG, 8'hfc);
      rd(fbr_pkg::CMD_RD_CFG, 8'hfd);
      settle();
      check("pull ups", pull_up, 16'h80e0);
      host_u.send(16'hb6fe, 16);
      settle();
      check("frame stages", stage_on, 16'ha100);
      rd(fbr_pkg::CMD_RD_INP_LO, 8'h96);
      host_u.send(16'h0000, 4);
      settle();
      check("short frame", stage_on, 16'ha107);
      // Serial and pin sources under parallel select
      serial_on = 16'h00a5;
      cmd(fbr_pkg::CMD_WR_CFG, 8'hff);
      settle();
      check("serial stages", stage_on, 16'h00a5);
      mux_serial = 16'hfffe;
      settle();
      check("pin stage", stage_on, 16'h00a4);
      // Enable line pulled low from outside
      en_ext = 1'b0;
      settle();
      check("line low stages", stage_on, 16'h0000);
      rd(fbr_pkg::CMD_RD_STAT, 8'hfb);
      en_ext = 1'b1;
      settle();
      // Overtemp, reset pin and stored overvoltage
      hot();
      rd(fbr_pkg::CMD_RD_STAT, 8'hef);
      mux_serial = 16'hff7f;
      serial_on = 16'hffff;
      ext_rst_n = 1'b0;
      settle();
      check("reset stages", stage_on, 16'h0080);
      // Stage 8 on its pin needs the supply floor
      above = 1'b0;
      settle();
      check("low supply stage", stage_on, 16'h0000);
      above = 1'b1;
      ov = 1'b1;
      settle();
      rd(fbr_pkg::CMD_RD_STAT, 8'hfa);
      ov = 1'b0;
      ext_rst_n = 1'b1;
      settle();
      rd(fbr_pkg::CMD_RD_STAT, 8'hfa);
      cmd(fbr_pkg::CMD_WR_STAT, 8'hdf);
      settle();
      rd(fbr_pkg::CMD_RD_STAT, 8'hdf);
      // Threshold tests, read-only bits unaffected by writes
      cmd(fbr_pkg::CMD_WR_STAT, 8'h40);
      settle();
      check("threshold", {14'h0000, raise, reduce}, 16'h0002);
      rd(fbr_pkg::CMD_RD_STAT, 8'h5f);
      cmd(fbr_pkg::CMD_WR_STAT, 8'h00);
      settle();
      check("threshold", {14'h0000, raise, reduce}, 16'h0001);
      rd(fbr_pkg::CMD_RD_STAT, 8'h1f);
      cmd(fbr_pkg::CMD_WR_STAT, 8'hff);
      hot();
      cmd(fbr_pkg::CMD_CLR_DIAG, 8'h00);
      rd(fbr_pkg::CMD_RD_STAT, 8'hff);
      uv = 1'b1;
      fault = 5'h04;
      settle();
      rd(fbr_pkg::CMD_RD_STAT, 8'hf1);
      summarize();
   end
endmodule : testbench
